// ---- src/clock_skew_power_config_regs.sv ----
// register bank for holdover averaging, buffer power and output skew
// What this block does
// RULE1: five-bit holdover averaging time in bits 7:3, register resets to C0.
// RULE2: bit 3 of output disable powers down second output and divider.
// RULE3: bit 2 of output disable powers down first output and divider.
// RULE4: input powerdown bit 1 disables the second input buffer.
// RULE5: input powerdown bit 0 disables the first input buffer.
// RULE6: with hardware stepping off, output delay is coarse value oscillator periods.
// RULE7: a coarse phase change may take up to twenty seconds to settle.
// RULE8: with high-speed divider 000, raising the coarse value has no effect.
// RULE9: host clears commit, writes all fine skew bytes, then sets commit.
// RULE10: commit low keeps the latched previous fine skew value.
// RULE11: commit high uses the fine skew value straight from the registers.
// RULE12: fine skew is 15 bits: high seven in 17[6:0], low eight in 18.
// RULE13: fine skew is two's complement; positive increases input-to-output skew.
// RULE14: hardware stepping select low makes increment and decrement pins ignored.
// RULE15: reserved bits read their reset values and ignore writes.
module clock_skew_power_config_regs
    import skew_cfg_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // register port from the serial control interface
    input wire logic [7:0] ADDR_I,
    input wire logic WR_I,
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O,
    // device context
    input wire logic HARDWARE_PHASE_STEP_SELECT_I,
    input wire logic [2:0] HIGH_SPEED_OUTPUT_DIVIDER_I,
    input wire logic INC_I,
    input wire logic DEC_I,
    // control outputs
    output logic [4:0] HOLDOVER_AVERAGING_TIME_O,
    output logic SECOND_OUTPUT_DISABLE_O,
    output logic FIRST_OUTPUT_DISABLE_O,
    output logic SECOND_INPUT_POWERDOWN_O,
    output logic FIRST_INPUT_POWERDOWN_O,
    output logic signed [7:0] COARSE_PHASE_O,
    output logic COARSE_UPDATE_O,
    output logic INC_STEP_O,
    output logic DEC_STEP_O,
    output logic signed [14:0] FINE_SKEW_VALUE_O
);
    logic [7:0] holdover_history_averaging;
    logic [7:0] output_buffer_disable;
    logic [7:0] input_buffer_powerdown;
    logic [7:0] coarse_phase_offset;
    logic [7:0] fine_skew_high_commit;
    logic [7:0] fine_skew_low;
    logic [7:0] next_holdover;
    logic [7:0] next_out_disable;
    logic [7:0] next_in_powerdown;
    logic [7:0] next_coarse;
    logic [7:0] next_fine_high;
    logic [7:0] next_fine_low;
    logic signed [7:0] applied_coarse;
    logic signed [7:0] next_applied_coarse;
    logic next_coarse_update;
    logic coarse_update;
    logic next_inc;
    logic next_dec;
    logic inc_step;
    logic dec_step;
    logic [14:0] fine_used;
    logic [7:0] next_rdata;
    logic [7:0] rdata;

    // merge a write into writable bits only, keeping reserved ones at reset
    function automatic logic [7:0] masked(input logic [7:0] wdata,
                                          input logic [7:0] mask,
                                          input logic [7:0] rst);
        masked = (wdata & mask) | (rst & ~mask);
    endfunction

    always_comb begin
        next_holdover = holdover_history_averaging;
        next_out_disable = output_buffer_disable;
        next_in_powerdown = input_buffer_powerdown;
        next_coarse = coarse_phase_offset;
        next_fine_high = fine_skew_high_commit;
        next_fine_low = fine_skew_low;
        if (WR_I) begin
            case (ADDR_I)
                ADDR_HOLDOVER: begin
                    next_holdover = masked(WDATA_I, WMASK_HOLDOVER,
                                           RST_HOLDOVER); // RULE1 RULE15
                end
                ADDR_OUT_DISABLE: begin
                    next_out_disable = masked(WDATA_I, WMASK_OUT_DISABLE,
                                              RST_OUT_DISABLE); // RULE15
                end
                ADDR_IN_POWERDOWN: begin
                    next_in_powerdown = masked(WDATA_I, WMASK_IN_POWERDOWN,
                                               RST_IN_POWERDOWN); // RULE15
                end
                ADDR_COARSE: begin
                    next_coarse = WDATA_I;
                end
                ADDR_FINE_HIGH: begin
                    next_fine_high = WDATA_I;
                end
                ADDR_FINE_LOW: begin
                    next_fine_low = WDATA_I;
                end
                default: begin
                    next_coarse = coarse_phase_offset;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            holdover_history_averaging <= RST_HOLDOVER;
            output_buffer_disable <= RST_OUT_DISABLE;
            input_buffer_powerdown <= RST_IN_POWERDOWN;
            coarse_phase_offset <= RST_COARSE;
            fine_skew_high_commit <= RST_FINE_HIGH;
            fine_skew_low <= RST_FINE_LOW;
        end else begin
            holdover_history_averaging <= next_holdover;
            output_buffer_disable <= next_out_disable;
            input_buffer_powerdown <= next_in_powerdown;
            coarse_phase_offset <= next_coarse;
            fine_skew_high_commit <= next_fine_high;
            fine_skew_low <= next_fine_low;
        end
    end

    // coarse phase applied to the output path; the analog settle of up to
    // COARSE_SETTLE_S seconds happens downstream, this only hands the target
    always_comb begin
        next_applied_coarse = applied_coarse;
        next_coarse_update = 1'b0;
        if (!HARDWARE_PHASE_STEP_SELECT_I &&
            applied_coarse != $signed(coarse_phase_offset)) begin // RULE6
            if ($signed(coarse_phase_offset) > applied_coarse &&
                HIGH_SPEED_OUTPUT_DIVIDER_I == HS_DIV_NO_INC) begin
                next_applied_coarse = applied_coarse; // RULE8
            end else begin
                next_applied_coarse = $signed(coarse_phase_offset);
                next_coarse_update = 1'b1; // RULE7
            end
        end
        // pins only act when hardware stepping is selected
        next_inc = HARDWARE_PHASE_STEP_SELECT_I & INC_I; // RULE14
        next_dec = HARDWARE_PHASE_STEP_SELECT_I & DEC_I; // RULE14
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            applied_coarse <= 8'sh00;
            coarse_update <= 1'b0;
            inc_step <= 1'b0;
            dec_step <= 1'b0;
        end else begin
            applied_coarse <= next_applied_coarse;
            coarse_update <= next_coarse_update;
            inc_step <= next_inc;
            dec_step <= next_dec;
        end
    end

    // RULE12 assembly of the 15-bit fine value from two registers
    fine_skew_hold u_fine_hold (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .commit_i(fine_skew_high_commit[COMMIT_BIT]),
        .reg_value_i({fine_skew_high_commit[6:0], fine_skew_low}),
        .value_o(fine_used)
    );

    always_comb begin
        case (ADDR_I)
            ADDR_HOLDOVER: next_rdata = holdover_history_averaging;
            ADDR_OUT_DISABLE: next_rdata = output_buffer_disable;
            ADDR_IN_POWERDOWN: next_rdata = input_buffer_powerdown;
            ADDR_COARSE: next_rdata = coarse_phase_offset;
            ADDR_FINE_HIGH: next_rdata = fine_skew_high_commit;
            ADDR_FINE_LOW: next_rdata = fine_skew_low;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign RDATA_O = rdata;
    assign HOLDOVER_AVERAGING_TIME_O =
        holdover_history_averaging[7:AVG_LSB]; // RULE1
    assign SECOND_OUTPUT_DISABLE_O =
        output_buffer_disable[SECOND_OUT_BIT]; // RULE2
    assign FIRST_OUTPUT_DISABLE_O =
        output_buffer_disable[FIRST_OUT_BIT]; // RULE3
    assign SECOND_INPUT_POWERDOWN_O =
        input_buffer_powerdown[SECOND_IN_BIT]; // RULE4
    assign FIRST_INPUT_POWERDOWN_O =
        input_buffer_powerdown[FIRST_IN_BIT]; // RULE5
    assign COARSE_PHASE_O = applied_coarse;
    assign COARSE_UPDATE_O = coarse_update;
    assign INC_STEP_O = inc_step;
    assign DEC_STEP_O = dec_step;
    assign FINE_SKEW_VALUE_O = $signed(fine_used); // RULE13
endmodule

// ---- src/fine_skew_hold.sv ----
// fine skew hold-and-commit latch
module fine_skew_hold
    import skew_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic commit_i,
    input wire logic [14:0] reg_value_i,
    output logic [14:0] value_o
);
    logic [14:0] held;
    logic [14:0] next_held;

    // the held copy tracks the registers while committed, freezes otherwise
    always_comb begin
        next_held = held;
        if (commit_i) begin
            next_held = reg_value_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held <= 15'h0000;
        end else begin
            held <= next_held;
        end
    end

    assign value_o = commit_i ? reg_value_i : held; // RULE10 RULE11
endmodule

// ---- src/skew_cfg_pkg.sv ----
// constants for the clock skew and power configuration registers
package skew_cfg_pkg;
    // register offsets
    localparam logic [7:0] ADDR_HOLDOVER = 8'h09;
    localparam logic [7:0] ADDR_OUT_DISABLE = 8'h0A;
    localparam logic [7:0] ADDR_IN_POWERDOWN = 8'h0B;
    localparam logic [7:0] ADDR_COARSE = 8'h10;
    localparam logic [7:0] ADDR_FINE_HIGH = 8'h11;
    localparam logic [7:0] ADDR_FINE_LOW = 8'h12;
    // reset values
    localparam logic [7:0] RST_HOLDOVER = 8'hC0;
    localparam logic [7:0] RST_OUT_DISABLE = 8'h00;
    localparam logic [7:0] RST_IN_POWERDOWN = 8'h40;
    localparam logic [7:0] RST_COARSE = 8'h00;
    localparam logic [7:0] RST_FINE_HIGH = 8'h80;
    localparam logic [7:0] RST_FINE_LOW = 8'h00;
    // writable bit masks; everything else is reserved
    localparam logic [7:0] WMASK_HOLDOVER = 8'hF8;
    localparam logic [7:0] WMASK_OUT_DISABLE = 8'h0C;
    localparam logic [7:0] WMASK_IN_POWERDOWN = 8'h03;
    // field positions
    localparam int AVG_LSB = 3;
    localparam int SECOND_OUT_BIT = 3;
    localparam int FIRST_OUT_BIT = 2;
    localparam int SECOND_IN_BIT = 1;
    localparam int FIRST_IN_BIT = 0;
    localparam int COMMIT_BIT = 7;
    localparam logic [2:0] HS_DIV_NO_INC = 3'h0;
    // settling allowance for a coarse phase change, in seconds
    localparam int COARSE_SETTLE_S = 20;
endpackage

// ---- verification/host.sv ----
// host model driving the register port
module host
    import skew_cfg_pkg::*;
(
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // idle data is inverted so a stale value cannot pass
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_o <= 1'b1;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask
    task fine(input logic [14:0] v);
        wr(ADDR_FINE_HIGH, {1'b0, v[14:8]});
        wr(ADDR_FINE_LOW, v[7:0]);
        wr(ADDR_FINE_HIGH, {1'b1, v[14:8]});
    endtask
endmodule

// ---- verification/skew_cfg_props.sv ----
// assertions on the register bank ports
module skew_cfg_props
    import skew_cfg_pkg::*;
(
    // clock, reset, register port and hardware step select
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic WR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic HARDWARE_PHASE_STEP_SELECT_I,
    // controls
    input wire logic [4:0] HOLDOVER_AVERAGING_TIME_O,
    input wire logic SECOND_OUTPUT_DISABLE_O,
    input wire logic FIRST_OUTPUT_DISABLE_O,
    input wire logic SECOND_INPUT_POWERDOWN_O,
    input wire logic FIRST_INPUT_POWERDOWN_O,
    input wire logic COARSE_UPDATE_O,
    input wire logic INC_STEP_O,
    input wire logic DEC_STEP_O,
    input wire logic signed [14:0] FINE_SKEW_VALUE_O
);
    logic [7:0] wd_q;
    logic commit_q;
    logic w_avg;
    logic w_out;
    logic w_in;
    logic w_low;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    assign w_avg = WR_I && ADDR_I == ADDR_HOLDOVER;
    assign w_out = WR_I && ADDR_I == ADDR_OUT_DISABLE;
    assign w_in = WR_I && ADDR_I == ADDR_IN_POWERDOWN;
    assign w_low = WR_I && ADDR_I == ADDR_FINE_LOW;
    // shadow of the commit bit, which has no port of its own
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wd_q <= 8'h00;
            commit_q <= 1'b1;
        end else begin
            wd_q <= WDATA_I;
            if (WR_I && ADDR_I == ADDR_FINE_HIGH) begin
                commit_q <= WDATA_I[COMMIT_BIT];
            end
        end
    end
    chk_avg_field: assert property (
        w_avg |=> HOLDOVER_AVERAGING_TIME_O == wd_q[7:3])
        else $error("averaging time not taken from write");
    chk_out2_off: assert property (
        w_out |=> SECOND_OUTPUT_DISABLE_O == wd_q[3])
        else $error("second output disable wrong");
    chk_out1_off: assert property (
        w_out |=> FIRST_OUTPUT_DISABLE_O == wd_q[2])
        else $error("first output disable wrong");
    chk_in2_off: assert property (
        w_in |=> SECOND_INPUT_POWERDOWN_O == wd_q[1])
        else $error("second input powerdown wrong");
    chk_in1_off: assert property (
        w_in |=> FIRST_INPUT_POWERDOWN_O == wd_q[0])
        else $error("first input powerdown wrong");
    chk_step_gated: assert property (
        !HARDWARE_PHASE_STEP_SELECT_I |=> !INC_STEP_O && !DEC_STEP_O)
        else $error("step pins not ignored");
    chk_coarse_frozen: assert property (
        HARDWARE_PHASE_STEP_SELECT_I |=> !COARSE_UPDATE_O)
        else $error("coarse phase moved while pins selected");
    chk_fine_held: assert property (
        w_low && !commit_q |=> $stable(FINE_SKEW_VALUE_O))
        else $error("fine skew followed partial write");
endmodule
bind clock_skew_power_config_regs skew_cfg_props i_skew_cfg_props (.*);

// ---- verification/tb_top.sv ----
// self-checking bench for the skew and power configuration registers
module tb_top
    import skew_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel = 1'b0;
    logic inc = 1'b0;
    logic dec = 1'b0;
    logic [2:0] hsd = 3'h1;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, d2, d1, p2, p1, upd, incs, decs;
    logic [4:0] avg;
    logic signed [7:0] cph;
    logic signed [14:0] fine;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] ra[7] = '{ADDR_HOLDOVER, ADDR_OUT_DISABLE, ADDR_IN_POWERDOWN,
        ADDR_COARSE, ADDR_FINE_HIGH, ADDR_FINE_LOW, 8'h00};
    logic [7:0] rv[7] = '{RST_HOLDOVER, RST_OUT_DISABLE, RST_IN_POWERDOWN,
        RST_COARSE, RST_FINE_HIGH, RST_FINE_LOW, 8'h00};
    always #20 clk = ~clk;
    host i_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
        .rdata_i(rdata));
    clock_skew_power_config_regs i_clock_skew_power_config_regs (
        .CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WR_I(wr),
        .WDATA_I(wdata), .RDATA_O(rdata),
        .HARDWARE_PHASE_STEP_SELECT_I(sel),
        .HIGH_SPEED_OUTPUT_DIVIDER_I(hsd), .INC_I(inc), .DEC_I(dec),
        .HOLDOVER_AVERAGING_TIME_O(avg), .SECOND_OUTPUT_DISABLE_O(d2),
        .FIRST_OUTPUT_DISABLE_O(d1), .SECOND_INPUT_POWERDOWN_O(p2),
        .FIRST_INPUT_POWERDOWN_O(p1), .COARSE_PHASE_O(cph),
        .COARSE_UPDATE_O(upd), .INC_STEP_O(incs), .DEC_STEP_O(decs),
        .FINE_SKEW_VALUE_O(fine));
    task results;
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [14:0] s, input logic [14:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wait_upd;
        int k;
        for (k = 0; k < 20 && upd !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        // judge by the pulse itself so a late but valid pulse is not a fail
        if (upd !== 1'b1) begin
            n_fail++;
            results();
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            i_host.rd(ra[i], v);
            chk("reset value", {7'h00, v}, {7'h00, rv[i]});
        end
        i_host.wr(ADDR_HOLDOVER, 8'hFF);
        i_host.wr(ADDR_OUT_DISABLE, 8'hFF);
        i_host.wr(ADDR_IN_POWERDOWN, 8'hFF);
        chk("averaging time", {10'h000, avg}, 15'h001F);
        chk("buffers off", {11'h000, d2, d1, p2, p1}, 15'h000F);
        i_host.rd(ADDR_IN_POWERDOWN, v);
        chk("powerdown readback", {7'h00, v}, 15'h0043);
        i_host.wr(ADDR_OUT_DISABLE, 8'h08);
        i_host.wr(ADDR_IN_POWERDOWN, 8'h01);
        chk("buffers mixed", {11'h000, d2, d1, p2, p1}, 15'h0009);
        i_host.wr(ADDR_COARSE, 8'h80);
        wait_upd();
        chk("coarse phase", {7'h00, cph}, 15'h0080);
        @(posedge clk);
        hsd <= HS_DIV_NO_INC;
        i_host.wr(ADDR_COARSE, 8'h05);
        repeat (10) @(posedge clk);
        #1;
        chk("coarse increase blocked", {7'h00, cph}, 15'h0080);
        @(posedge clk);
        hsd <= 3'h1;
        wait_upd();
        chk("coarse pending", {7'h00, cph}, 15'h0005);
        @(posedge clk);
        sel <= 1'b1;
        inc <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("step pins used", {13'h0000, incs, decs}, 15'h0002);
        @(posedge clk);
        sel <= 1'b0;
        dec <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("step pins ignored", {13'h0000, incs, decs}, 15'h0000);
        i_host.fine(15'h05AA);
        chk("fine skew", fine, 15'h05AA);
        i_host.wr(ADDR_FINE_HIGH, 8'h40);
        i_host.wr(ADDR_FINE_LOW, 8'h01);
        chk("fine skew held", fine, 15'h05AA);
        i_host.wr(ADDR_FINE_HIGH, 8'hC0);
        chk("fine skew sign", {14'h0000, fine < 0}, 15'h0001);
        i_host.wr(ADDR_FINE_LOW, 8'h7E);
        chk("fine skew live", fine, 15'h407E);
        results();
    end
endmodule
